// ### hdl/ccwd_decoder.sv
// ccwd_decoder: stores and decodes per-channel configuration words.
// assumes host strobes synchronous to core_clk_i, one access per cycle at most.
//
// How it works
// - words 0x0200-0x02FF, four slaves of 64
// - analog sensor type in bits 5..0
// - analog mode field in bits 9..7
// - filter code gives 1, 2, 4, 8 averaging
// - type 0 off, 1 and 2 millivolt ranges
// - type 3 plain resistance, wiring modes
// - types 4-18 thermocouples, burnout mode encoding
// - types 19-29 RTDs, 30 compensator input
// - mode bit 2 fixed junction, low bits burnout
// - down-scale/up-scale burnout force limit minus/plus one
// - coded burnout reports 0x7D00 to 0x7D03
// - resistance mode 0 three-wire, 1 four-wire
// - digital word: four modes, sixteen scan times
// - digital modes 0,2 off; 1 plain; 3 fault
// - power enabled input for scan-coded time first
// - disabled digital channel uses 500 us slot
// - non-coded out-of-range reads limit minus/plus one
`timescale 1ns/10ps
module ccwd_decoder (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    input wire logic [3:0] slave_digital_i,
    input wire logic [7:0] sel_chan_i,
    output ccwd_pkg::ccwd_class_t sens_class_o,
    output logic [5:0] sens_type_o,
    output ccwd_pkg::ccwd_burnout_t burnout_o,
    output logic cj_fixed_o,
    output logic four_wire_o,
    output logic [3:0] avg_depth_o,
    output logic dig_enable_o,
    output logic dig_fault_det_o,
    output logic [15:0] slot_us_o,
    input wire logic scan_start_i,
    output logic chan_power_o,
    output logic acquire_o,
    output logic slot_done_o,
    input wire logic [15:0] raw_i,
    input wire logic [15:0] lower_i,
    input wire logic [15:0] upper_i,
    input wire logic under_i,
    input wire logic over_i,
    input wire logic sens_bo_i,
    input wire logic cjc_bo_i,
    output logic [15:0] reading_o
);
    import ccwd_pkg::*;

    ccwd_mem_if mif ();

    ccwd_word_mem u_mem (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .mif(mif)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic in_cfg(input logic [15:0] a);
        in_cfg = (a >= CFG_BASE) && (a <= CFG_LAST);
    endfunction : in_cfg

    function automatic ccwd_class_t class_of(input logic [5:0] t);
        if (t == SENS_OFF) begin
            class_of = CLS_OFF;
        end else if (t == SENS_MV21 || t == SENS_MV80) begin
            class_of = CLS_MV;
        end else if (t == SENS_OHM) begin
            class_of = CLS_OHM;
        end else if (t >= SENS_TC_FIRST && t <= SENS_TC_LAST) begin
            class_of = CLS_TC;
        end else if (t >= SENS_RTD_FIRST && t <= SENS_RTD_LAST) begin
            class_of = CLS_RTD;
        end else if (t == SENS_CJC) begin
            class_of = CLS_CJC;
        end else begin
            class_of = CLS_UNDEF;
        end
    endfunction : class_of

    ////////////////////////////////////////////////////////////////////////
    // host access: one-cycle strobes, answered one cycle later
    logic ack;
    logic err;
    logic rd_pend;
    logic next_ack;
    logic next_err;
    logic next_rd_pend;
    logic hit;

    // channel index is the low byte: slave in bits 7..6, group of 16 in 5..4
    always_comb begin
        hit = in_cfg(reg_addr_i);
        mif.wr_en = reg_wr_i && hit;
        mif.wr_addr = reg_addr_i[7:0];
        mif.wr_data = reg_wdata_i;
        mif.host_addr = reg_addr_i[7:0];
        mif.dec_addr = sel_chan_i;
        next_ack = reg_wr_i || reg_rd_i;
        next_err = (reg_wr_i || reg_rd_i) && !hit;
        next_rd_pend = reg_rd_i && hit;
    end

    // answer flags
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            err <= 1'b0;
            rd_pend <= 1'b0;
        end else begin
            ack <= next_ack;
            err <= next_err;
            rd_pend <= next_rd_pend;
        end
    end
    assign reg_ack_o = ack;
    assign reg_err_o = err;
    // unmapped or write answers read as zero; store port is a flop
    assign reg_rdata_o = rd_pend ? mif.host_data : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // word decode for the selected channel
    logic [1:0] sel_slave;
    logic [1:0] next_sel_slave;
    ccwd_class_t cls;
    ccwd_class_t next_cls;
    logic [5:0] typ;
    logic [5:0] next_typ;
    ccwd_burnout_t bo;
    ccwd_burnout_t next_bo;
    logic cjf;
    logic next_cjf;
    logic wire4;
    logic next_wire4;
    logic [3:0] avg;
    logic [3:0] next_avg;
    logic den;
    logic next_den;
    logic dfd;
    logic next_dfd;
    logic [15:0] slot;
    logic [15:0] next_slot;
    logic [2:0] amode;
    logic [1:0] afilt;
    logic [1:0] dmode;
    logic [3:0] dscan;
    logic is_dig;

    always_comb begin
        next_sel_slave = sel_chan_i[7:6];
        is_dig = slave_digital_i[sel_slave];
        // reserved bits are never looked at
        next_typ = mif.dec_data[ANA_TYPE_LSB +: ANA_TYPE_W];
        amode = mif.dec_data[ANA_MODE_LSB +: ANA_MODE_W];
        afilt = mif.dec_data[ANA_FILT_LSB +: ANA_FILT_W];
        dmode = mif.dec_data[DIG_MODE_LSB +: DIG_MODE_W];
        dscan = mif.dec_data[DIG_SCAN_LSB +: DIG_SCAN_W];
        next_cls = is_dig ? CLS_OFF : class_of(next_typ);
        next_avg = 4'(1 << afilt);
        next_bo = BO_NONE;
        next_cjf = 1'b0;
        next_wire4 = 1'b0;
        if (next_cls == CLS_MV || next_cls == CLS_TC) begin
            next_cjf = amode[2];
            next_bo = ccwd_burnout_t'(amode[1:0]);
        end else if (next_cls == CLS_OHM || next_cls == CLS_RTD || next_cls == CLS_CJC) begin
            next_wire4 = (amode == 3'h1);
        end
        next_den = is_dig && dmode[0];
        next_dfd = is_dig && (dmode == 2'h3);
        next_slot = next_den ? SCAN_TIME_US[dscan] : OFF_SLOT_US;
        if (is_dig) begin
            next_avg = 4'h1;
            next_typ = 6'h00;
        end
    end

    // decoded fields, two cycles after the channel select
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_slave <= 2'h0;
            cls <= CLS_OFF;
            typ <= 6'h00;
            bo <= BO_NONE;
            cjf <= 1'b0;
            wire4 <= 1'b0;
            avg <= 4'h1;
            den <= 1'b0;
            dfd <= 1'b0;
            slot <= OFF_SLOT_US;
        end else begin
            sel_slave <= next_sel_slave;
            cls <= next_cls;
            typ <= next_typ;
            bo <= next_bo;
            cjf <= next_cjf;
            wire4 <= next_wire4;
            avg <= next_avg;
            den <= next_den;
            dfd <= next_dfd;
            slot <= next_slot;
        end
    end
    assign sens_class_o = cls;
    assign sens_type_o = typ;
    assign burnout_o = bo;
    assign cj_fixed_o = cjf;
    assign four_wire_o = wire4;
    assign avg_depth_o = avg;
    assign dig_enable_o = den;
    assign dig_fault_det_o = dfd;
    assign slot_us_o = slot;

    ////////////////////////////////////////////////////////////////////////
    // scan sequencer: power phase for enabled inputs, bare slot otherwise
    ccwd_seq_t st;
    ccwd_seq_t next_st;
    logic [6:0] div;
    logic [6:0] next_div;
    logic [15:0] us_cnt;
    logic [15:0] next_us_cnt;
    logic [15:0] dur;
    logic [15:0] next_dur;
    logic tick;
    logic last_us;
    logic next_acq;
    logic next_done;
    logic acq;
    logic done;

    always_comb begin
        tick = (div == TICK_CYCLES - 7'h01);
        last_us = tick && (us_cnt == dur - 16'h0001);
        next_st = st;
        next_div = tick ? 7'h00 : div + 7'h01;
        next_us_cnt = tick ? us_cnt + 16'h0001 : us_cnt;
        next_dur = dur;
        next_acq = 1'b0;
        next_done = 1'b0;
        case (st)
            SEQ_IDLE: begin
                next_div = 7'h00;
                next_us_cnt = 16'h0000;
                if (scan_start_i) begin
                    next_dur = slot;
                    next_st = den ? SEQ_POWER : SEQ_SLOT;
                end
            end
            SEQ_POWER, SEQ_SLOT: begin
                if (last_us) begin
                    next_acq = (st == SEQ_POWER);
                    next_done = 1'b1;
                    next_st = SEQ_IDLE;
                end
            end
            default: begin
                next_st = SEQ_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= SEQ_IDLE;
            div <= 7'h00;
            us_cnt <= 16'h0000;
            dur <= OFF_SLOT_US;
            acq <= 1'b0;
            done <= 1'b0;
        end else begin
            st <= next_st;
            div <= next_div;
            us_cnt <= next_us_cnt;
            dur <= next_dur;
            acq <= next_acq;
            done <= next_done;
        end
    end
    assign chan_power_o = (st == SEQ_POWER);
    assign acquire_o = acq;
    assign slot_done_o = done;

    ////////////////////////////////////////////////////////////////////////
    // reading formatter: off channels, burnout and range substitution
    logic [15:0] rd;
    logic [15:0] next_rd;

    always_comb begin
        next_rd = raw_i;
        if (slave_digital_i[sel_slave]) begin
            if (!den) begin
                next_rd = 16'h0000;
            end else if (!dfd) begin
                next_rd = {8'h00, raw_i[7:0]};
            end
        end else if (cls == CLS_OFF) begin
            next_rd = 16'h0000;
        end else if (bo == BO_CODED) begin
            if (cjc_bo_i) begin
                next_rd = CODE_CJC_BO;
            end else if (sens_bo_i) begin
                next_rd = CODE_SENS_BO;
            end else if (over_i) begin
                next_rd = CODE_OVER;
            end else if (under_i) begin
                next_rd = CODE_UNDER;
            end
        end else if (sens_bo_i && bo == BO_DOWN) begin
            next_rd = lower_i - 16'h0001;
        end else if (sens_bo_i && bo == BO_UP) begin
            next_rd = upper_i + 16'h0001;
        end else if (over_i) begin
            next_rd = upper_i + 16'h0001;
        end else if (under_i) begin
            next_rd = lower_i - 16'h0001;
        end
    end

    // registered reading
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd <= 16'h0000;
        end else begin
            rd <= next_rd;
        end
    end
    assign reading_o = rd;
endmodule : ccwd_decoder

// ### hdl/ccwd_mem_if.sv
// ccwd_mem_if: carries the configuration store's write and two read ports.
// assumes the store registers both read ports on core_clk_i.
`timescale 1ns/10ps
interface ccwd_mem_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic [7:0] host_addr;
    logic [15:0] host_data;
    logic [7:0] dec_addr;
    logic [15:0] dec_data;
    modport ctrl (output wr_en, wr_addr, wr_data, host_addr, dec_addr, input host_data, dec_data);
    modport mem (input wr_en, wr_addr, wr_data, host_addr, dec_addr, output host_data, dec_data);
endinterface : ccwd_mem_if

// ### hdl/ccwd_pkg.sv
// ccwd_pkg: constants and types of the channel configuration word decoder.
// assumes one 125 MHz clock; word addresses are 16-bit host word indexes.
package ccwd_pkg;
    ////////////////////////////////////////////////////////////////////////
    // address map
    localparam logic [15:0] CFG_BASE = 16'h0200;
    localparam logic [15:0] CFG_LAST = 16'h02FF;
    localparam int unsigned CHAN_AW = 8;
    localparam int unsigned WORD_W = 16;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    ////////////////////////////////////////////////////////////////////////
    // analog word fields
    localparam int unsigned ANA_TYPE_LSB = 0;
    localparam int unsigned ANA_TYPE_W = 6;
    localparam int unsigned ANA_MODE_LSB = 7;
    localparam int unsigned ANA_MODE_W = 3;
    localparam int unsigned ANA_FILT_LSB = 11;
    localparam int unsigned ANA_FILT_W = 2;
    // digital word fields
    localparam int unsigned DIG_MODE_LSB = 0;
    localparam int unsigned DIG_MODE_W = 2;
    localparam int unsigned DIG_SCAN_LSB = 3;
    localparam int unsigned DIG_SCAN_W = 4;
    ////////////////////////////////////////////////////////////////////////
    // sensor type codes
    localparam logic [5:0] SENS_OFF = 6'h00;
    localparam logic [5:0] SENS_MV21 = 6'h01;
    localparam logic [5:0] SENS_MV80 = 6'h02;
    localparam logic [5:0] SENS_OHM = 6'h03;
    localparam logic [5:0] SENS_TC_FIRST = 6'h04;
    localparam logic [5:0] SENS_TC_LAST = 6'h12;
    localparam logic [5:0] SENS_RTD_FIRST = 6'h13;
    localparam logic [5:0] SENS_RTD_LAST = 6'h1D;
    localparam logic [5:0] SENS_CJC = 6'h1E;
    // coded burnout values
    localparam logic [15:0] CODE_UNDER = 16'h7D00;
    localparam logic [15:0] CODE_OVER = 16'h7D01;
    localparam logic [15:0] CODE_SENS_BO = 16'h7D02;
    localparam logic [15:0] CODE_CJC_BO = 16'h7D03;
    ////////////////////////////////////////////////////////////////////////
    // timing: 1 us tick from the 8 ns clock
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_NS = 1000;
    localparam logic [6:0] TICK_CYCLES = 7'(TICK_NS / CLK_PERIOD_NS);
    localparam logic [15:0] OFF_SLOT_US = 16'h01F4; // 500 us
    // power-on time per scan code, in us: 1..6, 8..20 step 2, 25, 30, 35 ms
    localparam logic [15:0] SCAN_TIME_US [0:15] = '{
        16'h03E8, 16'h07D0, 16'h0BB8, 16'h0FA0, 16'h1388, 16'h1770, 16'h1F40, 16'h2710,
        16'h2EE0, 16'h36B0, 16'h3E80, 16'h4650, 16'h4E20, 16'h61A8, 16'h7530, 16'h88B8};
    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {CLS_OFF, CLS_MV, CLS_OHM, CLS_TC, CLS_RTD, CLS_CJC, CLS_UNDEF} ccwd_class_t;
    typedef enum logic [1:0] {BO_NONE, BO_DOWN, BO_UP, BO_CODED} ccwd_burnout_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_POWER, SEQ_SLOT} ccwd_seq_t;
endpackage : ccwd_pkg

// ### hdl/ccwd_word_mem.sv
// ccwd_word_mem: 256 configuration words, one write port, two registered reads.
// assumes one clock; words clear to the reset value under rst_i.
`timescale 1ns/10ps
module ccwd_word_mem (
    input wire logic core_clk_i,
    input wire logic rst_i,
    ccwd_mem_if.mem mif
);
    import ccwd_pkg::*;
    logic [15:0] words [0:255];
    logic [15:0] next_words [0:255];
    logic [15:0] host_q;
    logic [15:0] dec_q;
    ////////////////////////////////////////////////////////////////////////
    // write decode
    always_comb begin
        next_words = words;
        if (mif.wr_en) begin
            next_words[mif.wr_addr] = mif.wr_data;
        end
    end
    // storage and registered read ports
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 256; i++) begin
                words[i] <= CFG_RESET;
            end
            host_q <= 16'h0000;
            dec_q <= 16'h0000;
        end else begin
            words <= next_words;
            host_q <= words[mif.host_addr];
            dec_q <= words[mif.dec_addr];
        end
    end
    assign mif.host_data = host_q;
    assign mif.dec_data = dec_q;
endmodule : ccwd_word_mem

// ### testbench/ccwd_decoder_sva.sv
// ccwd_decoder_sva: port-level checks of the configuration word decoder.
// assumes one clock; bound to every ccwd_decoder instance.
`timescale 1ns/10ps
module ccwd_decoder_sva (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic reg_err_o,
    input var ccwd_pkg::ccwd_class_t sens_class_o,
    input wire logic [5:0] sens_type_o,
    input var ccwd_pkg::ccwd_burnout_t burnout_o,
    input wire logic cj_fixed_o,
    input wire logic four_wire_o,
    input wire logic dig_enable_o,
    input wire logic dig_fault_det_o,
    input wire logic [15:0] slot_us_o,
    input wire logic scan_start_i,
    input wire logic chan_power_o,
    input wire logic acquire_o,
    input wire logic slot_done_o
);
    import ccwd_pkg::*;
    logic busy, next_busy;
    logic [23:0] cnt, next_cnt, len, next_len;
    ////////////////////////////////////////
    // slot tracker: which start was taken, cycles since
    always_comb begin
        next_busy = busy;
        next_cnt = cnt + 24'h000001;
        next_len = len;
        if ((!busy || slot_done_o) && scan_start_i) begin
            next_busy = 1'b1;
            next_cnt = 24'h000000;
            next_len = 24'(slot_us_o) * 24'h00007D;
        end else if (slot_done_o) begin
            next_busy = 1'b0;
        end
    end
    // tracker registers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            cnt <= 24'h000000;
            len <= 24'h000000;
        end else begin
            busy <= next_busy;
            cnt <= next_cnt;
            len <= next_len;
        end
    end
    ////////////////////////////////////////
    // assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_strobe: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("no answer after strobe");
    chk_ack_cause: assert property (reg_ack_o |-> ($past(reg_wr_i) || $past(reg_rd_i)))
        else $error("answer without strobe");
    chk_err_range: assert property ((reg_wr_i || reg_rd_i) && (reg_addr_i < CFG_BASE || reg_addr_i > CFG_LAST)
        |=> reg_err_o && reg_rdata_o == 16'h0000) else $error("unmapped access not refused");
    chk_err_mapped: assert property ((reg_wr_i || reg_rd_i) && reg_addr_i >= CFG_BASE && reg_addr_i <= CFG_LAST
        |=> !reg_err_o) else $error("mapped access refused");
    chk_off_class: assert property (sens_type_o == SENS_OFF |-> sens_class_o == CLS_OFF)
        else $error("type 0 not off");
    chk_ohm_class: assert property (sens_type_o == SENS_OHM |-> sens_class_o == CLS_OHM)
        else $error("type 3 not resistance");
    chk_tc_class: assert property (sens_type_o inside {[SENS_TC_FIRST:SENS_TC_LAST]} |-> sens_class_o == CLS_TC)
        else $error("thermocouple class wrong");
    chk_rtd_class: assert property (sens_type_o inside {[SENS_RTD_FIRST:SENS_RTD_LAST]} |-> sens_class_o == CLS_RTD)
        else $error("resistance thermometer class wrong");
    chk_mode_scope: assert property (!(sens_class_o inside {CLS_MV, CLS_TC}) |-> burnout_o == BO_NONE && !cj_fixed_o)
        else $error("burnout mode outside mV or thermocouple");
    chk_wire_scope: assert property (four_wire_o |-> sens_class_o inside {CLS_OHM, CLS_RTD, CLS_CJC})
        else $error("four-wire outside resistance types");
    chk_fault_enable: assert property (dig_fault_det_o |-> dig_enable_o)
        else $error("fault detection on disabled channel");
    chk_off_slot: assert property (!dig_enable_o |-> slot_us_o == OFF_SLOT_US)
        else $error("disabled slot not 500 us");
    chk_slot_length: assert property (slot_done_o |-> busy && cnt == len)
        else $error("slot length wrong");
    chk_power_start: assert property (!busy && scan_start_i && dig_enable_o |=> chan_power_o [*2])
        else $error("enabled input not powered");
    chk_power_busy: assert property (chan_power_o |-> busy && len != 24'h00F424)
        else $error("power outside an enabled slot");
    chk_acquire_end: assert property (acquire_o |-> slot_done_o && $past(chan_power_o))
        else $error("acquire not at end of power phase");
endmodule : ccwd_decoder_sva

bind ccwd_decoder ccwd_decoder_sva ccwd_decoder_sva_inst (.core_clk_i, .rst_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_ack_o, .reg_err_o, .sens_class_o, .sens_type_o, .burnout_o, .cj_fixed_o,
    .four_wire_o, .dig_enable_o, .dig_fault_det_o, .slot_us_o, .scan_start_i, .chan_power_o, .acquire_o,
    .slot_done_o);

// ### testbench/ccwd_host_model.sv
// ccwd_host_model: host master on the decoder's register port.
// assumes one-cycle strobes answered one edge later.
`timescale 1ns/10ps
module ccwd_host_model (
    input wire logic core_clk_i,
    output logic [15:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_ack_i,
    input wire logic reg_err_i
);
    ////////////////////////////////////////
    // bus idle at time zero
    initial begin
        reg_addr_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end
    ////////////////////////////////////////
    // one access; released address and data show the inverse, strobes drop to zero
    task automatic xfer(input logic wr, input logic dig, input logic [15:0] addr, input logic [15:0] data,
                        output logic [15:0] rdata, output logic [1:0] resp);
        @(posedge core_clk_i);
        reg_addr_o <= addr;
        reg_wr_o <= wr;
        reg_rd_o <= ~wr;
        reg_wdata_o <= data & (dig ? 16'h007B : 16'h1BBF);
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
        #1;
        rdata = reg_rdata_i;
        resp = {reg_ack_i, reg_err_i};
    endtask : xfer
endmodule : ccwd_host_model

// ### testbench/tb.sv
// tb: self-checking bench of the configuration word decoder.
// assumes the host model drives the register port, this bench the rest.
`timescale 1ns/10ps
module tb;
    import ccwd_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, cj_fixed_o, four_wire_o, dig_enable_o, dig_fault_det_o;
    logic chan_power_o, acquire_o, slot_done_o;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, slot_us_o, reading_o;
    logic [15:0] raw_i = 16'h1234, lower_i = 16'h0100, upper_i = 16'h2000;
    logic under_i = 1'b0, over_i = 1'b0, sens_bo_i = 1'b0, cjc_bo_i = 1'b0, scan_start_i = 1'b0;
    logic [3:0] slave_digital_i = 4'h2;
    logic [7:0] sel_chan_i = 8'h00;
    logic [5:0] sens_type_o;
    logic [3:0] avg_depth_o;
    ccwd_class_t sens_class_o;
    ccwd_burnout_t burnout_o;
    int fails = 0, checks = 0, n;
    logic [15:0] aw [0:10] = '{16'h0000, 16'h0801, 16'h1002, 16'h1883, 16'h0384, 16'h0292, 16'h0113,
        16'h009D, 16'h009E, 16'h0102, 16'h001F};
    logic [15:0] ae [0:10] = '{16'h0001, 16'h0102, 16'h0104, 16'h0218, 16'h03E1, 16'h0361, 16'h0401,
        16'h0411, 16'h0511, 16'h0181, 16'h0601};
    logic [15:0] dw [0:3] = '{16'h0028, 16'h0001, 16'h007A, 16'h006B};
    logic [15:0] de [0:3] = '{16'h0000, 16'h0002, 16'h0000, 16'h0003};
    logic [15:0] ds [0:3] = '{16'h01F4, 16'h03E8, 16'h01F4, 16'h61A8};
    logic [15:0] dq [0:3] = '{16'h0000, 16'h0034, 16'h0000, 16'h1234};
    logic [15:0] rw [0:9] = '{16'h0186, 16'h0186, 16'h0186, 16'h0186, 16'h0186, 16'h0186, 16'h0086,
        16'h0106, 16'h0006, 16'h0006};
    logic [3:0] rc [0:9] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF, 4'h0, 4'h4, 4'h4, 4'h2, 4'h1};
    logic [15:0] re [0:9] = '{16'h7D03, 16'h7D02, 16'h7D01, 16'h7D00, 16'h7D03, 16'h1234, 16'h00FF,
        16'h2001, 16'h2001, 16'h00FF};
    ////////////////////////////////////////
    // design and host
    ccwd_decoder ccwd_decoder_inst (.core_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .reg_ack_o, .reg_err_o, .slave_digital_i, .sel_chan_i, .sens_class_o, .sens_type_o,
        .burnout_o, .cj_fixed_o, .four_wire_o, .avg_depth_o, .dig_enable_o, .dig_fault_det_o, .slot_us_o,
        .scan_start_i, .chan_power_o, .acquire_o, .slot_done_o, .raw_i, .lower_i, .upper_i, .under_i,
        .over_i, .sens_bo_i, .cjc_bo_i, .reading_o);
    ccwd_host_model ccwd_host_model_inst (.core_clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .reg_ack_i(reg_ack_o),
        .reg_err_i(reg_err_o));
    ////////////////////////////////////////
    // clock and watchdog
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (80000) @(posedge core_clk_i);
        fails++;
        final_report();
    end
    ////////////////////////////////////////
    // helpers
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic acc(input logic wr, input logic dig, input logic [15:0] a, input logic [15:0] d,
                       input logic [15:0] er, input logic [1:0] es);
        logic [15:0] rd;
        logic [1:0] rs;
        ccwd_host_model_inst.xfer(wr, dig, a, d, rd, rs);
        cmp("rdata", er, rd);
        cmp("resp", {14'h0000, es}, {14'h0000, rs});
    endtask : acc
    task automatic dec(input logic [7:0] ch);
        @(posedge core_clk_i);
        sel_chan_i <= ch;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask : dec
    function automatic logic [15:0] fld();
        return {5'h00, sens_class_o, burnout_o, cj_fixed_o, four_wire_o, avg_depth_o};
    endfunction : fld
    task automatic final_report;
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    // tests
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        cmp("rst_fields", 16'h0001, fld());
        cmp("rst_slot", 16'h01F4, slot_us_o);
        acc(1'b0, 1'b0, 16'h0200, 16'h0000, 16'h0000, 2'b10);
        acc(1'b1, 1'b0, 16'h02FF, 16'hFFFF, 16'h0000, 2'b10);
        acc(1'b0, 1'b0, 16'h02FF, 16'h0000, 16'h1BBF, 2'b10);
        acc(1'b1, 1'b0, 16'h0300, 16'h5555, 16'h0000, 2'b11);
        acc(1'b0, 1'b0, 16'h01FF, 16'h0000, 16'h0000, 2'b11);
        acc(1'b0, 1'b0, 16'h0200, 16'h0000, 16'h0000, 2'b10);
        for (int i = 0; i < 11; i++) begin
            acc(1'b1, 1'b0, 16'h0200 + 16'(i), aw[i], 16'h0000, 2'b10);
            dec(8'(i));
            cmp("analog", ae[i], fld());
            cmp("type", {10'h000, aw[i][5:0]}, {10'h000, sens_type_o});
        end
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 1'b1, 16'h0240 + 16'(i), dw[i], 16'h0000, 2'b10);
            dec(8'h40 + 8'(i));
            cmp("dig_mode", de[i], {14'h0000, dig_enable_o, dig_fault_det_o});
            cmp("dig_slot", ds[i], slot_us_o);
            cmp("dig_read", dq[i], reading_o);
        end
        acc(1'b0, 1'b1, 16'h0242, 16'h0000, 16'h007A, 2'b10);
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, 1'b0, 16'h0210, rw[i], 16'h0000, 2'b10);
            dec(8'h10);
            @(posedge core_clk_i);
            {cjc_bo_i, sens_bo_i, over_i, under_i} <= rc[i];
            repeat (2) @(posedge core_clk_i);
            #1;
            cmp("reading", re[i], reading_o);
        end
        dec(8'h41);
        @(posedge core_clk_i);
        scan_start_i <= 1'b1;
        @(posedge core_clk_i);
        scan_start_i <= 1'b0;
        #1;
        cmp("power", 16'h0001, {15'h0000, chan_power_o});
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        scan_start_i <= 1'b1;
        @(posedge core_clk_i);
        scan_start_i <= 1'b0;
        n = 0;
        while (n < 70000 && slot_done_o !== 1'b1) begin
            @(posedge core_clk_i);
            n++;
            scan_start_i <= (n == 100);
            #1;
        end
        cmp("slot_len", 16'hF424, 16'(n));
        final_report();
    end
endmodule : tb
